// *** hdl/osl_monitor.sv ***
// overspeed limit monitor: limit checks, acknowledge, start-up window
// Function
// - frequency above active upper limit opens both enable channels at once
// - re-close after upper trip needs acknowledge and frequency below limit minus margin
// - muting with both mode inputs high closes outputs inside measurable range
// - wire-break and invalid measurement still trip during muting
// - mode inputs mute by default, select upper limit when switching configured
// - both mode inputs high selects second limit, otherwise first limit
// - first limit trip re-closes after acknowledge below first limit minus margin
// - second limit trip re-closes after acknowledge below first limit minus margin
// - window ending without exceeding lower limit plus margin opens outputs
// - start-up window configurable from zero to sixty seconds
// - start conditions ignored while the start-up window runs
// - manual acknowledge starts the window on the acknowledge falling edge
// - automatic acknowledge starts the window once frequency exceeds 1 Hz
// - zero window closes outputs only inside the permitted range
// - manual acknowledge pulse counts only when high 200 ms to 5 s
// - below lower limit opens outputs, re-close only after acknowledge
`timescale 1ns/1ps
`include "osl_regs.svh"
module osl_monitor #(
  parameter int TICK_CYCLES = `OSL_TICK_CYCLES // cycles per 1 ms tick
) (
  input  wire logic                 ref_clk,      // 40 MHz clock
  input  wire logic                 nrst,         // async reset, active low
  input  wire osl_pkg::osl_freq_t   freq,         // measured field frequency
  input  wire logic                 freq_valid,   // sample valid
  input  wire logic                 wire_break,   // wire-break detected
  input  wire logic                 ack_pin,      // acknowledge pin, async
  input  wire logic                 mode_input_a, // mode pin a, async
  input  wire logic                 mode_input_b, // mode pin b, async
  input  wire osl_pkg::osl_cfg_t    cfg,          // static configuration
  output logic                      enable_ch1,   // enable channel 1, 1 closed
  output logic                      enable_ch2,   // enable channel 2, 1 closed
  output osl_pkg::osl_status_t      status        // trip cause and mode
);

  // three-stage synchronisers for the pins; level taken once stages 2 and 3 agree
  logic [2:0] pin_raw;
  logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  assign pin_raw = {mode_input_b, mode_input_a, ack_pin};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_comb begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        lvl_q[i] <= 1'b0;
      end else begin
        s1_q[i]  <= pin_raw[i];
        s2_q[i]  <= s1_q[i];
        s3_q[i]  <= s2_q[i];
        lvl_q[i] <= lvl_d[i];
      end
    end
  end

  logic ack_lvl, both_high;
  assign ack_lvl   = lvl_q[0];
  assign both_high = lvl_q[1] & lvl_q[2];

  logic mute, sel_two;
  assign mute    = both_high & ~cfg.mode_switching;
  assign sel_two = both_high & cfg.mode_switching;

  osl_pkg::osl_freq_t upper_act, range_max;
  assign upper_act = sel_two ? cfg.upper_limit_mode_two : cfg.upper_limit_mode_one;
  assign range_max = cfg.range_variant_hi ? `OSL_RANGE_HI : `OSL_RANGE_LO;

  // per-cycle comparisons, 17 bits so margins never wrap
  logic fault, over, under, in_range, below_one, above_lo_hys, above_start;
  assign fault        = wire_break | ~freq_valid;
  assign over         = mute ? (freq >= range_max) : (freq > upper_act);
  assign under        = ~mute && (cfg.lower_limit != '0) && (freq < cfg.lower_limit);
  assign in_range     = ~over & ~under;
  assign below_one    = ({1'b0, freq} + {1'b0, cfg.hysteresis}) < {1'b0, cfg.upper_limit_mode_one};
  assign above_lo_hys = {1'b0, freq} > ({1'b0, cfg.lower_limit} + {1'b0, cfg.hysteresis});
  assign above_start  = freq > `OSL_AUTO_START;

  // millisecond tick divider; one shared 1 ms tick keeps every timer counter narrow
  logic [15:0] div_q, div_d;
  logic        tick;
  assign tick = (div_q == 16'(TICK_CYCLES - 1));
  always_comb begin
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) div_q <= 16'h0000;
    else       div_q <= div_d;
  end

  // acknowledge pulse length, saturates just past the maximum
  logic [12:0] ack_ms_q, ack_ms_d;
  logic        ack_prev_q, ack_fall, ack_pulse_ok, ack_go;
  assign ack_fall     = ack_prev_q & ~ack_lvl;
  assign ack_pulse_ok = ack_fall && (ack_ms_q >= `OSL_ACK_MIN_MS) && (ack_ms_q <= `OSL_ACK_MAX_MS);
  assign ack_go       = cfg.ack_auto ? ack_lvl : ack_pulse_ok;
  always_comb begin
    ack_ms_d = ack_ms_q;
    if (!ack_lvl)
      ack_ms_d = 13'h0000;
    else if (tick && ack_ms_q <= `OSL_ACK_MAX_MS)
      ack_ms_d = ack_ms_q + 13'h0001;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ms_q   <= 13'h0000;
      ack_prev_q <= 1'b0;
    end else begin
      ack_ms_q   <= ack_ms_d;
      ack_prev_q <= ack_lvl;
    end
  end

  // window length in ms, clamped to sixty seconds
  logic [5:0]  win_s;
  logic [15:0] win_ms;
  assign win_s  = (cfg.startup_window_time > `OSL_WIN_MAX_S) ? `OSL_WIN_MAX_S : cfg.startup_window_time;
  assign win_ms = 16'({10'h000, win_s} * `OSL_MS_PER_S);

  // main state, window timer and trip causes
  osl_pkg::osl_state_t  st_q, st_d;
  osl_pkg::osl_status_t stat_q, stat_d;
  logic [15:0]          tmr_q, tmr_d;
  logic                 en_q, en_d, win_end, start_ok;
  assign win_end  = (tmr_q >= win_ms);
  // re-close always against first limit minus margin
  assign start_ok = ack_go && below_one && !fault && !over;

  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    stat_d = stat_q;
    stat_d.muting    = mute;
    stat_d.limit_two = sel_two;
    case (st_q)
      osl_pkg::OSL_OPEN: begin
        tmr_d = 16'h0000;
        // leave open state only on acknowledge
        if (start_ok) begin
          if (win_ms == 16'h0000 || mute) begin
            if (in_range) st_d = osl_pkg::OSL_RUN;
          end else if (!cfg.ack_auto || above_start) begin
            st_d = osl_pkg::OSL_STARTUP;
          end
        end
        if (st_d != osl_pkg::OSL_OPEN) stat_d = '{default: 1'b0, muting: mute, limit_two: sel_two};
      end
      osl_pkg::OSL_STARTUP: begin
        if (tick) tmr_d = tmr_q + 16'h0001;
        if (fault) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.fault_trip = 1'b1;
        end else if (over) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.over_trip = 1'b1;
        end else if (above_lo_hys || mute) begin
          st_d = osl_pkg::OSL_RUN;
        end else if (win_end) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.window_trip = 1'b1;
        end
      end
      osl_pkg::OSL_RUN: begin
        if (fault) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.fault_trip = 1'b1;
        end else if (over) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.over_trip = 1'b1;
        end else if (under) begin
          st_d = osl_pkg::OSL_OPEN;
          stat_d.under_trip = 1'b1;
        end
      end
      default: st_d = osl_pkg::OSL_OPEN;
    endcase
    en_d = (st_d != osl_pkg::OSL_OPEN);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= osl_pkg::OSL_OPEN;
      tmr_q  <= 16'h0000;
      stat_q <= '0;
      en_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      stat_q <= stat_d;
      en_q   <= en_d;
    end
  end

  // both channels from one flop; redundancy lives in the relays outside
  assign enable_ch1 = en_q;
  assign enable_ch2 = en_q;
  assign status     = stat_q;

  // checks on the design's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence run_over_s;
    (st_q == osl_pkg::OSL_RUN) && !fault && over;
  endsequence

  over_trip_a: assert property (run_over_s |=> !enable_ch1 && !enable_ch2 && status.over_trip)
    else $error("upper limit exceeded but outputs stayed closed");
  reclose_gate_a: assert property ($rose(en_q) |-> $past(below_one && !fault))
    else $error("outputs closed without first limit minus margin");
  mute_hold_a: assert property ((st_q == osl_pkg::OSL_RUN) && mute && !fault && freq < range_max |=> en_q)
    else $error("muting inside range did not keep outputs closed");
  wire_trip_a: assert property (en_q && fault |=> !en_q ##0 status.fault_trip)
    else $error("wire break did not open outputs");
  limit_select_a: assert property ((st_q == osl_pkg::OSL_RUN) && sel_two && !fault && !under
                                   && (freq > cfg.upper_limit_mode_one)
                                   && (freq <= cfg.upper_limit_mode_two) |=> en_q)
    else $error("second upper limit not in force while both mode inputs high");
  window_trip_a: assert property ((st_q == osl_pkg::OSL_STARTUP) && !fault && !over && !mute
                                  && !above_lo_hys && win_end |=> !en_q)
    else $error("start-up window expired without opening outputs");
  window_count_a: assert property ((st_q == osl_pkg::OSL_STARTUP) ##1 (st_q == osl_pkg::OSL_STARTUP)
                                   |-> tmr_q == $past(tmr_q) + 16'($past(tick)))
    else $error("start-up window restarted while running");
  ack_window_a: assert property (!cfg.ack_auto && (st_q == osl_pkg::OSL_OPEN) ##1 (st_q != osl_pkg::OSL_OPEN)
                                 |-> $past(ack_pulse_ok))
    else $error("manual re-close without valid acknowledge pulse");
  under_trip_a: assert property ((st_q == osl_pkg::OSL_RUN) && under |=> !en_q)
    else $error("below lower limit but outputs stayed closed");

endmodule

// *** hdl/osl_pkg.sv ***
// types shared by the overspeed limit monitor
`include "osl_regs.svh"
package osl_pkg;

  // frequencies are unsigned, in units of 0.1 Hz
  typedef logic [`OSL_FREQ_W-1:0] osl_freq_t;

  typedef struct packed {
    osl_freq_t                upper_limit_mode_one; // first upper limit
    osl_freq_t                upper_limit_mode_two; // second upper limit
    osl_freq_t                lower_limit;          // zero disables lower check
    osl_freq_t                hysteresis;           // margin for re-close
    logic [`OSL_WIN_W-1:0]    startup_window_time;  // seconds, 0..60
    logic                     ack_auto;             // 1 automatic, 0 manual
    logic                     mode_switching;       // 1 limit select, 0 muting
    logic                     range_variant_hi;     // 1 wide measurable range
  } osl_cfg_t;

  typedef struct packed {
    logic over_trip;   // upper limit exceeded
    logic under_trip;  // below lower limit
    logic fault_trip;  // wire break or invalid sample
    logic window_trip; // start-up window expired
    logic muting;      // limit checking suppressed
    logic limit_two;   // second upper limit in force
  } osl_status_t;

  typedef enum logic [2:0] {
    OSL_OPEN    = 3'h1,
    OSL_STARTUP = 3'h2,
    OSL_RUN     = 3'h4
  } osl_state_t;

endpackage

// *** hdl/osl_regs.svh ***
// timing counts, limits and field widths of the overspeed limit monitor
`ifndef OSL_REGS_SVH
`define OSL_REGS_SVH

`define OSL_FREQ_W        16
`define OSL_WIN_W         6
`define OSL_CLK_PERIOD_NS 25
`define OSL_TICK_NS       1000000
`define OSL_TICK_CYCLES   (`OSL_TICK_NS / `OSL_CLK_PERIOD_NS)
`define OSL_ACK_MIN_MS    13'h00C8
`define OSL_ACK_MAX_MS    13'h1388
`define OSL_MS_PER_S      16'h03E8
`define OSL_WIN_MAX_S     6'h3C
`define OSL_AUTO_START    16'h000A
`define OSL_RANGE_LO      16'h3A98
`define OSL_RANGE_HI      16'h4650

`endif

// *** tb/osl_monitor_tb.sv ***
// self-checking bench for the overspeed limit monitor
`timescale 1ns/1ps
module osl_monitor_tb;
  logic                 ref_clk = 0, nrst = 0, freq_valid = 1, wire_break = 0;
  logic                 mode_input_a = 0, mode_input_b = 0, go = 0, hold = 0;
  logic [15:0]          ms = 16'h0000;
  osl_pkg::osl_freq_t   freq = 16'h0005;
  osl_pkg::osl_cfg_t    cfg = '0;
  logic                 ack_pin, busy, enable_ch1, enable_ch2;
  osl_pkg::osl_status_t status;
  int                   n_fail = 0, check_count = 0, cyc = 0;
  // bit positions of the status flags
  localparam int OVR = 5, UND = 4, FLT = 3, WTR = 2, MUT = 1, LTW = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  osl_monitor #(.TICK_CYCLES(4)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .freq(freq),
    .freq_valid(freq_valid), .wire_break(wire_break), .ack_pin(ack_pin), .mode_input_a(mode_input_a),
    .mode_input_b(mode_input_b), .cfg(cfg), .enable_ch1(enable_ch1), .enable_ch2(enable_ch2),
    .status(status));
  osl_plant_model #(.TICK(4)) plant_u (.ref_clk(ref_clk), .go(go), .ms(ms), .hold_high(hold),
    .ack_pin(ack_pin), .busy(busy));

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // both channels must agree, so they are compared as a pair; read mid-cycle once settled
  task automatic chk_en(input logic e);
    @(negedge ref_clk);
    check_count++;
    if ({enable_ch1, enable_ch2} !== {e, e}) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, {e, e}, {enable_ch1, enable_ch2});
    end
    @(posedge ref_clk);
  endtask

  // one status flag by bit position, read mid-cycle so the edge's update has landed
  task automatic chk_st(input int b, input logic e);
    @(negedge ref_clk);
    check_count++;
    if (status[b] !== e) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, status[b]);
    end
    @(posedge ref_clk);
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic setf(input logic [15:0] f);
    freq <= f;
    tk(6);
  endtask

  // pulse on the pin, then allow synchroniser and state edges
  task automatic ack(input logic [15:0] m);
    int k = 0;
    ms <= m;
    go <= 1'b1;
    tk(1);
    go <= 1'b0;
    while (busy === 1'b1 && k < 30000) begin
      tk(1);
      k++;
    end
    tk(8);
  endtask

  // limits 100 Hz, 200 Hz, lower 20 Hz, margin 5 Hz
  task automatic rst(input logic [5:0] w, input logic au, input logic sw);
    nrst <= 1'b0;
    hold <= au;
    // pins low again so an earlier muting request does not leak into the next scenario
    mode_input_a <= 1'b0;
    mode_input_b <= 1'b0;
    freq <= 16'h0005;
    // first limit below second; lower limit above 1.1 Hz
    cfg <= '{16'h03E8, 16'h07D0, 16'h00C8, 16'h0032, w, au, sw, 1'b0};
    tk(12);
    nrst <= 1'b1;
    tk(2);
  endtask

  // hang guard, about twice the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    rst(6'h01, 1'b0, 1'b0);
    chk_en(1'b0);
    setf(16'h01F4);
    ack(16'h00FA); chk_en(1'b1);
    setf(16'h03E9); chk_en(1'b0);
    chk_st(OVR, 1'b1);
    setf(16'h03C0); ack(16'h00FA); chk_en(1'b0);
    setf(16'h03AC); ack(16'h00FA); chk_en(1'b1);
    setf(16'h0064); chk_en(1'b0);
    chk_st(UND, 1'b1);
    ack(16'h0064); chk_en(1'b0);
    ack(16'h1388); chk_en(1'b1);
    ack(16'h00C8); chk_en(1'b1);
    tk(3250); chk_en(1'b0);
    chk_st(WTR, 1'b1);
    // mode switching with zero window
    rst(6'h00, 1'b0, 1'b1);
    setf(16'h01F4);
    mode_input_a <= 1'b1;
    mode_input_b <= 1'b1;
    tk(8); chk_st(LTW, 1'b1);
    ack(16'h00FA); setf(16'h05DC); chk_en(1'b1);
    setf(16'h07D1); chk_en(1'b0);
    setf(16'h05DC); ack(16'h00FA); chk_en(1'b0);
    mode_input_a <= 1'b0;
    mode_input_b <= 1'b0;
    setf(16'h03AC); ack(16'h00FA); chk_en(1'b1);
    setf(16'h04B0); chk_en(1'b0);
    // muting with zero window
    rst(6'h00, 1'b0, 1'b0);
    setf(16'h0064); ack(16'h00FA); chk_en(1'b0);
    setf(16'h01F4); ack(16'h00FA); chk_en(1'b1);
    mode_input_a <= 1'b1;
    mode_input_b <= 1'b1;
    tk(8); chk_st(MUT, 1'b1);
    setf(16'h2710); chk_en(1'b1);
    setf(16'h3A98); chk_en(1'b0);
    // wide measurable range variant, changed while the outputs are open
    cfg.range_variant_hi <= 1'b1;
    setf(16'h01F4); ack(16'h00FA); chk_en(1'b1);
    setf(16'h3A98); chk_en(1'b1);
    setf(16'h4650); chk_en(1'b0);
    chk_st(OVR, 1'b1);
    setf(16'h01F4); ack(16'h00FA); chk_en(1'b1);
    wire_break <= 1'b1;
    tk(6); chk_en(1'b0);
    chk_st(FLT, 1'b1);
    wire_break <= 1'b0;
    ack(16'h00FA); chk_en(1'b1);
    freq_valid <= 1'b0;
    tk(6); chk_en(1'b0);
    freq_valid <= 1'b1;
    // automatic acknowledge, 1 s window
    rst(6'h01, 1'b1, 1'b0);
    tk(20); chk_en(1'b0);
    setf(16'h000F); tk(4); chk_en(1'b1);
    tk(3900); chk_en(1'b1);
    freq <= 16'h0000;
    tk(200); chk_en(1'b0);
    chk_st(WTR, 1'b1);
    give_verdict();
  end
endmodule

// *** tb/osl_plant_model.sv ***
// partner model: operator acknowledge pin behind the monitor
`timescale 1ns/1ps
module osl_plant_model #(
  parameter int TICK = 4 // cycles per ms tick
) (
  input  wire logic        ref_clk,   // device clock
  input  wire logic        go,        // start one acknowledge pulse
  input  wire logic [15:0] ms,        // pulse length in ms
  input  wire logic        hold_high, // automatic mode wiring
  output logic             ack_pin,   // acknowledge pin
  output logic             busy       // pulse still running
);
  int cnt = 0;

  always @(posedge ref_clk) begin
    if (go) cnt <= int'(ms) * TICK;
    else if (cnt > 0) cnt <= cnt - 1;
  end

  // pin wired high in automatic mode
  assign ack_pin = hold_high || (cnt > 0);
  assign busy    = go || (cnt > 0); // covers the load edge too
endmodule
